//--- verilog/rsp_serial_port.sv
`timescale 1ns/1ps
`include "rsp_params.svh"

// Summary of operation
// - Status byte at 10h: bit0 alarm A flag, bit1 alarm B flag, rest zero.
// - Alarm A match sets alarm A flag.
// - Alarm A flag with its enable pulls first interrupt low.
// - Pointer landing on any alarm A register clears alarm A flag.
// - Alarm B match sets alarm B flag.
// - Routing select high: alarm B flag with enable pulls second interrupt low.
// - Routing select low: alarm B flag with enable pulls first interrupt low.
// - Pointer landing on any alarm B register clears alarm B flag.
// - Charger byte read at 11h, written at 91h.
// - Charger runs only with unlock field exactly 1010.
// - Reset leaves charger off; config byte 0101_11_00.
// - Diode field 01 one diode, 10 two; 00 and 11 disable.
// - Resistor field 01/10/11 pick 2k/4k/8k; 00 disables.
// - Interface pin high selects four-wire, low selects three-wire.
// - Slave only; master makes the shift clock.
// - Chip enable frames a transfer; its fall ends it.
// - Clock idle polarity sampled when chip enable rises.
// - Input captured on strobe edge, output changed on opposite edge.
// - One clock per bit; bytes of eight, MSB first in four-wire.
// - Address byte first, then data bytes; reads out, writes in.
// - Address bit 7 zero reads, one writes.
// - Pointer advances per byte, wrapping 1Fh to 00h, 9Fh to 80h.
module rsp_serial_port (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic SCLK,
  input wire logic SERIAL_IN,
  output logic SDO_O,
  output logic SDO_OE,
  input wire logic IFACE_SELECT_PIN,
  input wire logic ALARM_A_MATCH,
  input wire logic ALARM_B_MATCH,
  input wire logic ALARM_A_IRQ_ENABLE,
  input wire logic ALARM_B_IRQ_ENABLE,
  input wire logic IRQ_ROUTING_SELECT,
  output logic IRQ_OUT_A_N,
  output logic IRQ_OUT_B_N,
  output logic CHARGER_ON,
  output logic CHARGER_TWO_DIODES,
  output logic [1:0] CHARGER_RESISTOR,
  output logic [7:0] EXT_RD_ADDR,
  input wire logic [7:0] EXT_RD_DATA,
  output logic [7:0] EXT_WR_ADDR,
  output logic [7:0] EXT_WR_DATA,
  output logic EXT_WR_STB
);
  import rsp_pkg::*;

  rsp_state_type st_r;
  rsp_state_type st_nxt;
  logic ce_s;
  logic sclk_s;
  logic sdi_s;
  logic mode_s;
  logic sclk_rise;
  logic sclk_fall;
  logic strobe;
  logic shift_edge;
  logic [7:0] rd_byte;
  logic alarm_a_hit;
  logic alarm_b_hit;
  logic [1:0] diode_count_field;
  logic [1:0] resistor_field;
  logic [3:0] charger_unlock_field;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  rsp_sync_if #(.W(4)) pin_if ();

  assign pin_if.raw = {IFACE_SELECT_PIN, SERIAL_IN, SCLK, CE};

  rsp_sync2 #(.W(4)) u_sync (
    .clk(CLK),
    .rst_n(RSTN),
    .sif(pin_if)
  );

  assign ce_s = pin_if.sync[0];
  assign sclk_s = pin_if.sync[1];
  assign sdi_s = pin_if.sync[2];
  assign mode_s = pin_if.sync[3];

  // ----------------------------------------
  // Edge decode
  // ----------------------------------------
  assign sclk_rise = sclk_s & ~st_r.sclk_d;
  assign sclk_fall = ~sclk_s & st_r.sclk_d;
  // Strobe is the edge back to idle level; three-wire samples on rise
  assign strobe = st_r.three_wire ? sclk_rise : (st_r.cpol ? sclk_rise : sclk_fall);
  assign shift_edge = st_r.three_wire ? sclk_fall : (st_r.cpol ? sclk_fall : sclk_rise);

  // ----------------------------------------
  // Read data selection
  // ----------------------------------------
  always_comb
  begin
    if (st_r.addr[6:0] == `RSP_ADDR_STATUS)
      rd_byte = {6'h00, st_r.alarm_b_flag, st_r.alarm_a_flag};
    else if (st_r.addr[6:0] == `RSP_ADDR_CHARGER)
      rd_byte = st_r.cfg;
    else
      rd_byte = EXT_RD_DATA;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [7:0] byte_in;
    logic [7:0] word;
    logic [7:0] next_addr;
    logic ptr_moved;
    byte_in = 8'h00;
    word = 8'h00;
    next_addr = 8'h00;
    ptr_moved = 1'b0;
    st_nxt = st_r;
    st_nxt.wr_stb = 1'b0;
    st_nxt.ce_d = ce_s;
    st_nxt.sclk_d = sclk_s;
    if (!ce_s)
    begin
      // Chip enable low ends the frame wherever it stands
      st_nxt.phase = PH_IDLE;
      st_nxt.bit_cnt = 3'h0;
      st_nxt.sdo_en = 1'b0;
    end
    else if (!st_r.ce_d)
    begin
      st_nxt.cpol = sclk_s;
      st_nxt.three_wire = ~mode_s;
      st_nxt.phase = PH_ADDR;
      st_nxt.bit_cnt = 3'h0;
    end
    else
    begin
      if (strobe && st_r.phase != PH_IDLE)
      begin
        // Four-wire is MSB first, three-wire LSB first
        byte_in = st_r.three_wire ? {sdi_s, st_r.shreg[7:1]} : {st_r.shreg[6:0], sdi_s};
        st_nxt.shreg = byte_in;
        st_nxt.bit_cnt = st_r.bit_cnt + 3'h1;
        if (st_r.bit_cnt == `RSP_LAST_BIT)
        begin
          ptr_moved = 1'b1;
          if (st_r.phase == PH_ADDR)
          begin
            st_nxt.addr = byte_in;
            st_nxt.phase = PH_DATA;
          end
          else
          begin
            if (st_r.addr[`RSP_DIR_BIT])
            begin
              // Status byte is read-only; a write there is dropped
              if (st_r.addr[6:0] == `RSP_ADDR_CHARGER)
                st_nxt.cfg = byte_in;
              else if (st_r.addr[6:0] != `RSP_ADDR_STATUS)
              begin
                st_nxt.wr_stb = 1'b1;
                st_nxt.wr_data = byte_in;
                st_nxt.wr_addr = st_r.addr;
              end
            end
            if (st_r.addr[6:0] == `RSP_CLK_WRAP_TOP)
              next_addr = {st_r.addr[7], `RSP_CLK_WRAP_BASE};
            else if (st_r.addr[6:0] == `RSP_RAM_WRAP_TOP)
              next_addr = {st_r.addr[7], `RSP_RAM_WRAP_BASE};
            else
              next_addr = {st_r.addr[7], st_r.addr[6:0] + 7'h01};
            st_nxt.addr = next_addr;
          end
        end
      end
      // Read data is fetched at the first shift edge, once the pointer has settled
      if (shift_edge && st_r.phase == PH_DATA && !st_r.addr[`RSP_DIR_BIT])
      begin
        word = (st_r.bit_cnt == 3'h0) ? rd_byte : st_r.out_reg;
        st_nxt.serial_out = st_r.three_wire ? word[0] : word[7];
        st_nxt.out_reg = st_r.three_wire ? {1'b0, word[7:1]} : {word[6:0], 1'b0};
        st_nxt.sdo_en = 1'b1;
      end
    end
    // Pointer landing on an alarm register clears its flag; a match in the same cycle wins
    if (ptr_moved && st_nxt.addr[6:0] >= `RSP_ALARM_A_FIRST && st_nxt.addr[6:0] <= `RSP_ALARM_A_LAST)
      st_nxt.alarm_a_flag = 1'b0;
    if (ptr_moved && st_nxt.addr[6:0] >= `RSP_ALARM_B_FIRST && st_nxt.addr[6:0] <= `RSP_ALARM_B_LAST)
      st_nxt.alarm_b_flag = 1'b0;
    if (ALARM_A_MATCH)
      st_nxt.alarm_a_flag = 1'b1;
    if (ALARM_B_MATCH)
      st_nxt.alarm_b_flag = 1'b1;
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      st_r <= '0;
      st_r.phase <= PH_IDLE;
      st_r.cfg <= `RSP_CHARGER_RESET;
    end
    else
      st_r <= st_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign alarm_a_hit = st_r.alarm_a_flag & ALARM_A_IRQ_ENABLE;
  assign alarm_b_hit = st_r.alarm_b_flag & ALARM_B_IRQ_ENABLE;
  // Level outputs; they release as soon as the flag clears
  assign IRQ_OUT_A_N = ~(alarm_a_hit | (alarm_b_hit & ~IRQ_ROUTING_SELECT));
  assign IRQ_OUT_B_N = ~(alarm_b_hit & IRQ_ROUTING_SELECT);

  assign charger_unlock_field = st_r.cfg[`RSP_UNLOCK_MSB:`RSP_UNLOCK_LSB];
  assign diode_count_field = st_r.cfg[`RSP_DIODE_MSB:`RSP_DIODE_LSB];
  assign resistor_field = st_r.cfg[`RSP_RES_MSB:`RSP_RES_LSB];
  // Key pattern guards against a stray write switching the charger on
  assign CHARGER_ON = (charger_unlock_field == `RSP_UNLOCK_KEY)
    && (diode_count_field == `RSP_DIODE_ONE || diode_count_field == `RSP_DIODE_TWO)
    && (resistor_field != `RSP_RES_OFF);
  assign CHARGER_TWO_DIODES = (diode_count_field == `RSP_DIODE_TWO);
  assign CHARGER_RESISTOR = resistor_field;

  // Slave only: nothing here drives the shift clock
  assign SDO_O = st_r.serial_out;
  assign SDO_OE = st_r.sdo_en;
  assign EXT_RD_ADDR = st_r.addr;
  assign EXT_WR_ADDR = st_r.wr_addr;
  assign EXT_WR_DATA = st_r.wr_data;
  assign EXT_WR_STB = st_r.wr_stb;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RSTN);

  property p_alarm_a_set;
    ALARM_A_MATCH |=> st_r.alarm_a_flag;
  endproperty
  a_alarm_a_set: assert property (p_alarm_a_set) else $error("alarm A flag not set by match");

  property p_alarm_b_set;
    ALARM_B_MATCH |=> st_r.alarm_b_flag;
  endproperty
  a_alarm_b_set: assert property (p_alarm_b_set) else $error("alarm B flag not set by match");

  property p_irq_a_low;
    st_r.alarm_a_flag && ALARM_A_IRQ_ENABLE |-> !IRQ_OUT_A_N;
  endproperty
  a_irq_a_low: assert property (p_irq_a_low) else $error("first interrupt not asserted");

  property p_irq_b_route;
    st_r.alarm_b_flag && ALARM_B_IRQ_ENABLE |-> (IRQ_ROUTING_SELECT ? !IRQ_OUT_B_N : !IRQ_OUT_A_N);
  endproperty
  a_irq_b_route: assert property (p_irq_b_route) else $error("alarm B interrupt misrouted");

  property p_irq_b_idle;
    !IRQ_ROUTING_SELECT |-> IRQ_OUT_B_N;
  endproperty
  a_irq_b_idle: assert property (p_irq_b_idle) else $error("second interrupt active while unrouted");

  property p_alarm_a_clear;
    !$past(ALARM_A_MATCH) && st_r.addr != $past(st_r.addr) && st_r.addr[6:0] >= `RSP_ALARM_A_FIRST
      && st_r.addr[6:0] <= `RSP_ALARM_A_LAST |-> !st_r.alarm_a_flag;
  endproperty
  a_alarm_a_clear: assert property (p_alarm_a_clear) else $error("alarm A flag survived pointer");

  property p_charger_key;
    CHARGER_ON |-> st_r.cfg[7:4] == 4'hA && st_r.cfg[1:0] != 2'h0 && ^st_r.cfg[3:2];
  endproperty
  a_charger_key: assert property (p_charger_key) else $error("charger on without valid setting");

  property p_sdo_frame;
    SDO_OE |-> $past(ce_s) && st_r.addr[7] == 1'b0;
  endproperty
  a_sdo_frame: assert property (p_sdo_frame) else $error("serial output driven outside read frame");

  property p_cpol_capture;
    ce_s && !st_r.ce_d |=> st_r.cpol == $past(sclk_s) && st_r.phase == PH_ADDR;
  endproperty
  a_cpol_capture: assert property (p_cpol_capture) else $error("clock polarity not captured");

  property p_frame_end;
    !ce_s |=> st_r.phase == PH_IDLE && !SDO_OE;
  endproperty
  a_frame_end: assert property (p_frame_end) else $error("frame not ended by chip enable");

  property p_wrap;
    st_r.phase == PH_DATA && strobe && st_r.bit_cnt == 3'h7 && st_r.addr[6:0] == 7'h1F
      |=> st_r.addr == {$past(st_r.addr[7]), 7'h00};
  endproperty
  a_wrap: assert property (p_wrap) else $error("clock address did not wrap");

  property p_alarm_b_clear;
    !$past(ALARM_B_MATCH) && st_r.addr != $past(st_r.addr) && st_r.addr[6:0] >= `RSP_ALARM_B_FIRST
      && st_r.addr[6:0] <= `RSP_ALARM_B_LAST |-> !st_r.alarm_b_flag;
  endproperty
  a_alarm_b_clear: assert property (p_alarm_b_clear) else $error("alarm B flag survived pointer");

  property p_status_byte;
    st_r.addr[6:0] == `RSP_ADDR_STATUS |-> rd_byte[7:2] == 6'h00 && rd_byte[0] == st_r.alarm_a_flag
      && rd_byte[1] == st_r.alarm_b_flag;
  endproperty
  a_status_byte: assert property (p_status_byte) else $error("status byte layout wrong");

  property p_status_no_write;
    st_r.wr_stb |-> st_r.wr_addr[6:0] != `RSP_ADDR_STATUS && st_r.wr_addr[6:0] != `RSP_ADDR_CHARGER;
  endproperty
  a_status_no_write: assert property (p_status_no_write) else $error("local byte sent to external write");

  property p_cfg_write;
    ce_s && st_r.ce_d && st_r.phase == PH_DATA && strobe && st_r.bit_cnt == 3'h7 && st_r.addr == 8'h91
      |=> st_r.cfg == st_r.shreg;
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("charger byte not written");

  property p_unlock_off;
    st_r.cfg[7:4] != 4'hA |-> !CHARGER_ON;
  endproperty
  a_unlock_off: assert property (p_unlock_off) else $error("charger on without unlock key");

  property p_res_off;
    st_r.cfg[1:0] == 2'h0 |-> !CHARGER_ON && CHARGER_RESISTOR == 2'h0;
  endproperty
  a_res_off: assert property (p_res_off) else $error("charger on with no resistor");

  property p_mode_capture;
    ce_s && !st_r.ce_d |=> st_r.three_wire == !$past(mode_s);
  endproperty
  a_mode_capture: assert property (p_mode_capture) else $error("interface mode not captured");

  property p_irq_release;
    !st_r.alarm_a_flag && !st_r.alarm_b_flag |-> IRQ_OUT_A_N && IRQ_OUT_B_N;
  endproperty
  a_irq_release: assert property (p_irq_release) else $error("interrupt held without flag");

  property p_byte_length;
    ce_s && st_r.ce_d && st_r.phase == PH_ADDR && strobe && st_r.bit_cnt == 3'h7
      |=> st_r.phase == PH_DATA && st_r.bit_cnt == 3'h0;
  endproperty
  a_byte_length: assert property (p_byte_length) else $error("address byte not eight bits");

endmodule

//--- verilog/rsp_params.svh
`ifndef RSP_PARAMS_SVH
`define RSP_PARAMS_SVH

// ----------------------------------------
// Address map (low seven bits of pointer)
// ----------------------------------------
`define RSP_DIR_BIT 7
`define RSP_ADDR_STATUS 7'h10
`define RSP_ADDR_CHARGER 7'h11
`define RSP_ALARM_A_FIRST 7'h07
`define RSP_ALARM_A_LAST 7'h0A
`define RSP_ALARM_B_FIRST 7'h0B
`define RSP_ALARM_B_LAST 7'h0E
`define RSP_CLK_WRAP_TOP 7'h1F
`define RSP_CLK_WRAP_BASE 7'h00
`define RSP_RAM_WRAP_TOP 7'h7F
`define RSP_RAM_WRAP_BASE 7'h20

// ----------------------------------------
// Charger configuration fields
// ----------------------------------------
`define RSP_CHARGER_RESET 8'h5C
`define RSP_UNLOCK_MSB 7
`define RSP_UNLOCK_LSB 4
`define RSP_UNLOCK_KEY 4'hA
`define RSP_DIODE_MSB 3
`define RSP_DIODE_LSB 2
`define RSP_RES_MSB 1
`define RSP_RES_LSB 0
`define RSP_DIODE_ONE 2'h1
`define RSP_DIODE_TWO 2'h2
`define RSP_RES_OFF 2'h0

// ----------------------------------------
// Shift timing
// ----------------------------------------
`define RSP_LAST_BIT 3'h7

`endif

//--- verilog/rsp_pkg.sv
package rsp_pkg;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10
  } rsp_phase_type;

  typedef struct packed {
    logic ce_d;
    logic sclk_d;
    logic cpol;
    logic three_wire;
    rsp_phase_type phase;
    logic [2:0] bit_cnt;
    logic [7:0] shreg;
    logic [7:0] out_reg;
    logic [7:0] addr;
    logic serial_out;
    logic sdo_en;
    logic alarm_a_flag;
    logic alarm_b_flag;
    logic [7:0] cfg;
    logic [7:0] wr_data;
    logic [7:0] wr_addr;
    logic wr_stb;
  } rsp_state_type;

endpackage

//--- verilog/rsp_sync_if.sv
`timescale 1ns/1ps
interface rsp_sync_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport owner (output raw, input sync);
  modport sync_end (input raw, output sync);
endinterface

//--- verilog/rsp_sync2.sv
`timescale 1ns/1ps
module rsp_sync2 #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  rsp_sync_if.sync_end sif
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // ----------------------------------------
  // Two flops; first stage feeds only the second
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else
    begin
      meta_r <= sif.raw;
      sync_r <= meta_r;
    end
  end

  assign sif.sync = sync_r;
endmodule

//--- tb/rsp_master_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Serial bus master model
// ----------------------------------------
module rsp_master_model (
  input wire logic clk,
  input wire logic io_in,
  output logic ce,
  output logic sclk,
  output logic m_d,
  output logic m_oe
);
  initial
  begin
    ce = 1'h0;
    sclk = 1'h0;
    m_d = 1'h0;
    m_oe = 1'h0;
  end

  // Address byte then n data bytes; rd is the first data byte
  task automatic frame(input logic [7:0] a, input logic [7:0] wd, input int n, input logic p,
    input logic three, output logic [7:0] rd);
    logic [7:0] x;
    logic b;
    rd = 8'h00;
    @(negedge clk);
    sclk = p;  // Clock idles before select so the device sees its level
    #160;
    ce = 1'h1;
    #160;
    for (int k = 0; k <= n; k++)
    begin
      x = (k == 0) ? a : wd;
      for (int i = 0; i < 8; i++)
      begin
        m_oe = (k == 0) || a[7];  // Line released for read data
        m_d = three ? x[i] : x[7 - i];
        if (three)
        begin
          #160;
          b = io_in;
          sclk = 1'h1;
          #160;
          sclk = 1'h0;
        end
        else
        begin
          sclk = ~p;
          #160;
          b = io_in;
          sclk = p;
          #160;
        end
        if (k == 1)
          rd = three ? {b, rd[7:1]} : {rd[6:0], b};
      end
    end
    m_oe = 1'h0;
    #160;
    ce = 1'h0;
    #480;
  endtask
endmodule

//--- tb/rtc_serial_port_alarm_flags_test.sv
`timescale 1ns/1ps
module rtc_serial_port_alarm_flags_test;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic ifsel = 1'h1;
  logic am = 1'h0;
  logic bm = 1'h0;
  logic ae = 1'h0;
  logic be = 1'h0;
  logic rsel = 1'h1;
  logic p = 1'h0;
  logic ce, sclk, m_d, m_oe, io, sdo_o, sdo_oe, irq_a_n, irq_b_n, chg_on, chg_two, wr_stb;
  logic [1:0] chg_res;
  logic [7:0] rd_addr, wr_addr, wr_data, wa, wdv, r;
  logic [7:0] cfg [6] = '{8'hA5, 8'hAA, 8'hA7, 8'hAC, 8'hA8, 8'h55};
  int err_count = 0;
  int checks_done = 0;

  always #20 clk = ~clk;
  // Undriven wire shows the inverse so a stale value never passes
  assign io = sdo_oe ? sdo_o : (m_oe ? m_d : ~m_d);

  rsp_serial_port u_dut (.CLK(clk), .RSTN(rstn), .CE(ce), .SCLK(sclk), .SERIAL_IN(io), .SDO_O(sdo_o),
    .SDO_OE(sdo_oe), .IFACE_SELECT_PIN(ifsel), .ALARM_A_MATCH(am), .ALARM_B_MATCH(bm),
    .ALARM_A_IRQ_ENABLE(ae), .ALARM_B_IRQ_ENABLE(be), .IRQ_ROUTING_SELECT(rsel),
    .IRQ_OUT_A_N(irq_a_n), .IRQ_OUT_B_N(irq_b_n), .CHARGER_ON(chg_on), .CHARGER_TWO_DIODES(chg_two),
    .CHARGER_RESISTOR(chg_res), .EXT_RD_ADDR(rd_addr), .EXT_RD_DATA(rd_addr ^ 8'h5A),
    .EXT_WR_ADDR(wr_addr), .EXT_WR_DATA(wr_data), .EXT_WR_STB(wr_stb));
  rsp_master_model u_master (.clk(clk), .io_in(io), .ce(ce), .sclk(sclk), .m_d(m_d), .m_oe(m_oe));

  always @(posedge clk)
    if (wr_stb)
    begin
      wa <= wr_addr;
      wdv <= wr_data;
    end

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask

  task automatic xf(input logic [7:0] a, input logic [7:0] wd, input int n);
    u_master.frame(a, wd, n, p, ~ifsel, r);
  endtask

  task automatic hit(input logic b);
    @(negedge clk);
    if (b)
      bm = 1'h1;
    else
      am = 1'h1;
    @(negedge clk);
    am = 1'h0;
    bm = 1'h0;
    @(negedge clk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    #400000;
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (12) @(negedge clk);
    rstn = 1'h1;
    repeat (4) @(negedge clk);
    chk1("charger_on", 1'h0, chg_on);
    xf(8'h11, 8'h00, 1);
    chk8("charger_config", 8'h5C, r);
    foreach (cfg[i])
    begin
      xf(8'h91, cfg[i], 1);
      chk1("charger_on", cfg[i][7:4] == 4'hA && cfg[i][3:2] inside {2'h1, 2'h2} && cfg[i][1:0] != 2'h0,
        chg_on);
      chk1("two_diodes", cfg[i][3:2] == 2'h2, chg_two);
      chk8("resistor", {6'h00, cfg[i][1:0]}, {6'h00, chg_res});
      xf(8'h11, 8'h00, 1);
      chk8("charger_config", cfg[i], r);
    end
    ae = 1'h1;
    hit(1'h0);
    chk1("irq_a_n", 1'h0, irq_a_n);
    ae = 1'h0;
    @(negedge clk);
    chk1("irq_a_n", 1'h1, irq_a_n);
    ae = 1'h1;
    xf(8'h10, 8'h00, 1);
    chk8("status", 8'h01, r);
    xf(8'h09, 8'h00, 1);
    chk8("ext_read", 8'h53, r);
    chk1("irq_a_n", 1'h1, irq_a_n);
    chk1("sdo_oe", 1'h0, sdo_oe);
    be = 1'h1;
    rsel = 1'h0;
    hit(1'h1);
    chk1("irq_a_n", 1'h0, irq_a_n);
    chk1("irq_b_n", 1'h1, irq_b_n);
    rsel = 1'h1;
    @(negedge clk);
    chk1("irq_a_n", 1'h1, irq_a_n);
    chk1("irq_b_n", 1'h0, irq_b_n);
    xf(8'h10, 8'h00, 1);
    chk8("status", 8'h02, r);
    xf(8'h8E, 8'h77, 1);
    chk1("irq_b_n", 1'h1, irq_b_n);
    chk8("wr_addr", 8'h8E, wa);
    chk8("wr_data", 8'h77, wdv);
    xf(8'h9F, 8'h66, 2);
    chk8("wr_addr", 8'h80, wa);
    xf(8'h90, 8'hFF, 1);
    chk8("wr_addr", 8'h80, wa);
    xf(8'h10, 8'h00, 1);
    chk8("status", 8'h00, r);
    hit(1'h0);
    chk1("irq_a_n", 1'h0, irq_a_n);
    xf(8'h06, 8'h00, 1);
    chk8("ext_read", 8'h5C, r);
    chk1("irq_a_n", 1'h1, irq_a_n);
    hit(1'h1);
    chk1("irq_b_n", 1'h0, irq_b_n);
    xf(8'h8A, 8'h12, 1);
    chk1("irq_b_n", 1'h1, irq_b_n);
    chk8("wr_data", 8'h12, wdv);
    p = 1'h1;
    xf(8'h11, 8'h00, 1);
    chk8("charger_config", 8'h55, r);
    p = 1'h0;
    ifsel = 1'h0;
    xf(8'h91, 8'hA6, 1);
    chk1("charger_on", 1'h1, chg_on);
    xf(8'h11, 8'h00, 1);
    chk8("charger_config", 8'hA6, r);
    tally_and_finish();
  end
endmodule
